/* File: sim/ccc_bridge_model.sv */
`default_nettype none
module ccc_bridge_model
    import ccc_pkg::*;
(
    input  wire logic             pclk,       // System clock
    input  wire logic             presetn,    // Async reset, active low
    input  wire ccc_drive_t [1:0] coil_drive, // Bridge command per coil
    input  wire logic       [1:0] stuck_high, // Bench-commanded comparator fault
    output logic            [1:0] comp_above  // Comparator per coil
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [9:0] cur [2];

    // Coarse coil: rises while driven, falls in fast decay, holds in slow decay
    always_ff @(posedge pclk or negedge presetn) begin
        for (int c = 0; c < 2; c++) begin
            if (!presetn) begin
                cur[c] <= 10'h000;
            end else begin
                case (coil_drive[c].phase)
                    PH_ON:   cur[c] <= (cur[c] == 10'h3FF) ? cur[c] : cur[c] + 10'h001;
                    PH_FAST: cur[c] <= (cur[c] == 10'h000) ? cur[c] : cur[c] - 10'h001;
                    PH_OFF:  cur[c] <= 10'h000;
                    default: cur[c] <= cur[c];
                endcase
            end
        end
    end

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            comp_above[c] = stuck_high[c] | (cur[c] > {2'b00, coil_drive[c].threshold});
        end
    end
endmodule
`default_nettype wire

/* File: sim/coil_current_chopper_control_tb_top.sv */
`default_nettype none
module coil_current_chopper_control_tb_top
    import ccc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic             pclk       = 1'b0;
    logic             presetn    = 1'b0;
    logic             psel       = 1'b0;
    logic             penable    = 1'b0;
    logic             pwrite     = 1'b0;
    logic      [7:0]  paddr      = 8'h00;
    logic      [31:0] pwdata     = 32'h00000000;
    logic      [3:0]  pstrb      = 4'hF;
    logic      [31:0] prdata;
    logic             pready;
    logic             pslverr;
    logic      [1:0]  comp_above;
    logic      [1:0]  stuck_high = 2'b00;
    ccc_drive_t [1:0] coil_drive;
    int               n_errors   = 0;
    int               cmp_count  = 0;

    always #2 pclk = ~pclk;

    ccc_chopper u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .comp_above(comp_above), .coil_drive(coil_drive));

    ccc_bridge_model u_model (.pclk(pclk), .presetn(presetn), .coil_drive(coil_drive),
        .stuck_high(stuck_high), .comp_above(comp_above));

    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic rng(input string nm, input int lo, input int hi, input int got);
        cmp_count++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask

    // One APB transfer; the answer is waited for, never assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic eerr);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h00000000, r, e);
        chk(nm, exp, r);
        chk("pslverr", {31'h0, eerr}, {31'h0, e});
    endtask

    // Passing through zero slow length restarts both choppers from OFF
    task automatic cfg(input ccc_conf_t cf);
        ccc_conf_t z;
        z = cf;
        z.slow_decay_length = 4'h0;
        wr(OFS_CONF, {6'h00, z});
        repeat (4) @(posedge pclk);
        chk("off_a", 32'(PH_OFF), 32'(coil_drive[0].phase));
        chk("off_b", 32'(PH_OFF), 32'(coil_drive[1].phase));
        wr(OFS_CONF, {6'h00, cf});
    endtask

    task automatic wait_ph(input int c, input ccc_phase_t ph);
        int i;
        for (i = 0; i < 5000; i++) begin
            @(negedge pclk);
            if (coil_drive[c].phase === ph) break;
        end
        if (i == 5000) begin
            n_errors++;
            results();
        end
    endtask

    task automatic run_ph(input int c, input ccc_phase_t ph, output int len, output ccc_phase_t nxt);
        // A phase already showing is timed from here, so none of its cycles is lost
        if (coil_drive[c].phase !== ph) begin
            wait_ph(c, ph);
        end
        len = 0;
        while (coil_drive[c].phase === ph && len < 5000) begin
            @(negedge pclk);
            len++;
        end
        if (len == 5000) begin
            n_errors++;
            results();
        end
        nxt = coil_drive[c].phase;
    endtask

    initial begin
        ccc_conf_t  cf;
        ccc_phase_t nxt;
        int         len;
        int         iv;
        int         sl;
        int         nv;
        int         bl [4];
        bl = '{int'(BLANK_0), int'(BLANK_1), int'(BLANK_2), int'(BLANK_3)};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;

        rd("conf", OFS_CONF, 32'h00000000, 1'b0);
        rd("tgt_a", OFS_TARGET_A, 32'h00000000, 1'b0);
        rd("tgt_b", OFS_TARGET_B, 32'h00000000, 1'b0);
        rd("status", OFS_STATUS, 32'h00000021, 1'b0);
        rd("unmapped", 8'h10, 32'h00000000, 1'b1);
        wr(8'h10, 32'hFFFFFFFF);
        wr(OFS_STATUS, 32'hFFFFFFFF);
        wr(OFS_TARGET_A, 32'hFFFFFFFF);
        rd("conf_kept", OFS_CONF, 32'h00000000, 1'b0);
        rd("status_ro", OFS_STATUS, 32'h00000021, 1'b0);
        rd("tgt_a_w", OFS_TARGET_A, 32'h000001FF, 1'b0);
        chk("polarity", 32'h1, {31'h0, coil_drive[0].polarity});
        wr(OFS_TARGET_A, 32'h000000C8);
        wr(OFS_TARGET_B, 32'h00000028);
        $display("test registers done");

        cf = '0;
        cf.hyst_start_offset = 3'h6;
        cf.hyst_end_value = 4'h0;
        for (int d = 0; d < 4; d++) begin
            cf.hyst_decrement_interval = d[1:0];
            cf.slow_decay_length = 4'(d + 1);
            cfg(cf);
            iv = (d + 1) * 16;
            sl = int'(SLOW_MULT) * (d + 1) + int'(SLOW_BASE);
            wait_ph(0, PH_ON);
            repeat (iv / 2) @(negedge pclk);
            chk("thr_start", 32'h000000CC, 32'(coil_drive[0].threshold));
            repeat (iv) @(negedge pclk);
            chk("thr_dec", 32'h000000CB, 32'(coil_drive[0].threshold));
            // Only the fastest decrement reaches the floor before the on phase ends
            if (d == 0) begin
                repeat (iv * 6) @(negedge pclk);
                chk("thr_floor", 32'h000000C5, 32'(coil_drive[0].threshold));
            end
            run_ph(0, PH_ON, len, nxt);
            chk("thr_slow", 32'h000000C8, 32'(coil_drive[0].threshold));
            chk("on_next", 32'(PH_SLOW1), 32'(nxt));
            run_ph(0, PH_SLOW1, len, nxt);
            rng("slow1_len", sl, sl, len);
            chk("slow1_next", 32'(PH_FAST), 32'(nxt));
            run_ph(0, PH_FAST, len, nxt);
            chk("fast_next", 32'(PH_SLOW2), 32'(nxt));
            run_ph(0, PH_SLOW2, len, nxt);
            rng("slow2_len", sl, sl, len);
            chk("slow2_next", 32'(PH_ON), 32'(nxt));
        end
        $display("test hysteresis done");

        cf.slow_decay_length = 4'h2;
        stuck_high <= 2'b01;
        for (int t = 0; t < 4; t++) begin
            cf.blank_interval = t[1:0];
            cfg(cf);
            run_ph(0, PH_ON, len, nxt);
            rng("on_blank", bl[t] + 1, bl[t] + 4, len);
            chk("blank_next", 32'(PH_SLOW1), 32'(nxt));
        end
        stuck_high <= 2'b00;
        $display("test blanking done");

        cf.blank_interval = 2'h0;
        cf.slow_decay_length = 4'h1;
        cf.random_offtime_enable = 1'b1;
        cfg(cf);
        nv = 0;
        for (int k = 0; k < 6; k++) begin
            run_ph(0, PH_SLOW1, len, nxt);
            rng("rnd_slow", 56, 71, len);
            if (len != 56) nv++;
        end
        chk("rnd_varies", 32'h1, {31'h0, nv != 0});
        $display("test random done");

        wr(OFS_TARGET_A, 32'h00000064);
        cf = '0;
        cf.slow_decay_length = 4'h1;
        cf.chopper_scheme_select = 1'b1;
        cf.fast_decay_time = 4'h2;
        cf.sine_offset = 4'hF;
        cf.fast_decay_timer_only = 1'b1;
        cfg(cf);
        wait_ph(0, PH_ON);
        repeat (4) @(negedge pclk);
        chk("thr_offset", 32'h00000070, 32'(coil_drive[0].threshold));
        chk("thr_offset_b", 32'h00000034, 32'(coil_drive[1].threshold));
        run_ph(0, PH_ON, len, nxt);
        chk("ot_on_next", 32'(PH_FAST), 32'(nxt));
        run_ph(0, PH_FAST, len, nxt);
        rng("ot_fast_len", int'(FAST_MULT) * 2, int'(FAST_MULT) * 2, len);
        chk("ot_fast_next", 32'(PH_SLOW2), 32'(nxt));
        run_ph(0, PH_SLOW2, len, nxt);
        rng("ot_slow_len", 56, 56, len);
        chk("ot_slow_next", 32'(PH_ON), 32'(nxt));
        run_ph(1, PH_ON, len, nxt);
        chk("b_on_next", 32'(PH_FAST), 32'(nxt));
        cf.fast_decay_timer_only = 1'b0;
        cfg(cf);
        run_ph(0, PH_ON, len, nxt);
        run_ph(0, PH_FAST, len, nxt);
        rng("ot_fast_comp", 1, 63, len);
        cf.fast_decay_time = 4'h0;
        cf.sine_offset = 4'h0;
        cfg(cf);
        wait_ph(0, PH_ON);
        repeat (4) @(negedge pclk);
        chk("thr_neg", 32'h00000061, 32'(coil_drive[0].threshold));
        run_ph(0, PH_ON, len, nxt);
        chk("slow_only", 32'(PH_SLOW2), 32'(nxt));
        $display("test off-time done");
        results();
    end
endmodule
`default_nettype wire

/* File: verilog/ccc_chopper.sv */
// Register access over APB and the placing of the registers are this design's own decisions.
`default_nettype none
module ccc_chopper
    import ccc_pkg::*;
(
    input  wire logic             pclk,       // System clock
    input  wire logic             presetn,    // Async reset, active low
    input  wire logic             psel,       // APB select
    input  wire logic             penable,    // APB enable
    input  wire logic             pwrite,     // APB direction
    input  wire logic [7:0]       paddr,      // APB byte address
    input  wire logic [31:0]      pwdata,     // APB write data
    input  wire logic [3:0]       pstrb,      // APB byte strobes
    output logic      [31:0]      prdata,     // APB read data
    output logic                  pready,     // APB ready
    output logic                  pslverr,    // APB error, unmapped address
    input  wire logic [1:0]       comp_above, // Sense above threshold, per coil
    output ccc_drive_t [1:0]      coil_drive  // Bridge phase, polarity, threshold
);
    typedef struct packed {
        ccc_conf_t             conf;
        logic [1:0][8:0]       target;
        logic [1:0]            cmp_meta;
        logic [1:0]            cmp_sync;
        ccc_coil_t [1:0]       coil;
        logic                  pready;
        logic                  pslverr;
        logic [31:0]           prdata;
    } ccc_state_t;

    ccc_state_t  r;
    ccc_state_t  next_r;
    logic [15:0] rnd;

    ccc_lfsr #(
        .WIDTH (16),
        .TAPS  (16'hB400),
        .SEED  (16'hACE1)
    ) u_rnd (
        .pclk    (pclk),
        .presetn (presetn),
        .rnd     (rnd)
    );

    function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [5:0] blank_cycles(input logic [1:0] code);
        logic [5:0] n;
        unique case (code)
            2'h0: n = BLANK_0;
            2'h1: n = BLANK_1;
            2'h2: n = BLANK_2;
            2'h3: n = BLANK_3;
        endcase
        return n;
    endfunction

    function automatic logic [9:0] slow_cycles(input logic [3:0] len, input logic en, input logic [3:0] rv);
        logic [9:0] n;
        n = 10'({6'h00, len} * SLOW_MULT) + SLOW_BASE;
        if (en) begin
            n = n + {6'h00, rv};
        end
        return n;
    endfunction

    // Interval minus one, so the counter wraps at the interval
    function automatic logic [5:0] dec_last(input logic [1:0] code);
        logic [6:0] n;
        n = 7'({5'h00, code} + 7'h01) * HYST_DECREMENT_INTERVAL_STEP;
        return 6'(n - 7'h01);
    endfunction

    function automatic logic signed [5:0] hyst_end_value_eff(input logic [3:0] code);
        return $signed({2'h0, code}) - $signed(HYST_END_VALUE_BIAS);
    endfunction

    function automatic logic signed [5:0] hstart_eff(input ccc_conf_t c);
        return hyst_end_value_eff(c.hyst_end_value) + $signed({3'h0, c.hyst_start_offset}) + 6'sh01;
    endfunction

    // Comparator threshold for the bridge, clamped into the 8-bit range
    function automatic logic [7:0] thr_calc(input logic [7:0] mag, input ccc_conf_t c,
                                            input ccc_phase_t ph, input logic signed [5:0] h);
        logic signed [10:0] adj;
        logic signed [10:0] v;
        adj = 11'sh000;
        if (c.chopper_scheme_select) begin
            adj = $signed({5'h00, 2'h0, c.sine_offset}) - $signed({5'h00, OFFSET_BIAS});
        end else if (ph == PH_ON) begin
            adj = {{5{h[5]}}, h};
        end else if (ph == PH_FAST) begin
            adj = -{{5{h[5]}}, h};
        end
        v = $signed({3'h0, mag}) + adj;
        if (v < 11'sh000) begin
            return 8'h00;
        end else if (v > 11'sh0FF) begin
            return 8'hFF;
        end
        return v[7:0];
    endfunction

    always_comb begin
        ccc_coil_t   cs;
        ccc_coil_t   ns;
        logic        cmp;
        logic        blanked;
        logic        new_cycle;
        logic [31:0] rd;
        ccc_conf_t   cf;
        cs = '0;
        ns = '0;
        cmp = 1'b0;
        blanked = 1'b0;
        new_cycle = 1'b0;
        rd = 32'h00000000;
        cf = r.conf;
        next_r = r;

        // APB: answer one cycle after setup, write lands on the access edge
        next_r.pready = psel & ~penable;
        if (psel && !penable) begin
            next_r.pslverr = 1'b0;
            unique case (paddr)
                OFS_CONF:     rd = {6'h00, r.conf};
                OFS_TARGET_A: rd = {23'h000000, r.target[0]};
                OFS_TARGET_B: rd = {23'h000000, r.target[1]};
                OFS_STATUS:   rd = {8'h00, r.cmp_sync, r.coil[1].hyst, r.coil[0].hyst,
                                    r.coil[1].drv.phase, r.coil[0].drv.phase};
                default:      next_r.pslverr = 1'b1;
            endcase
            next_r.prdata = pwrite ? 32'h00000000 : rd;
        end
        if (psel && penable && r.pready && pwrite && !r.pslverr) begin
            if (paddr == OFS_CONF) begin
                next_r.conf = ccc_conf_t'(26'(wr_merge({6'h00, r.conf}, pwdata, pstrb)));
            end
            if (paddr == OFS_TARGET_A) begin
                next_r.target[0] = 9'(wr_merge({23'h000000, r.target[0]}, pwdata, pstrb));
            end
            if (paddr == OFS_TARGET_B) begin
                next_r.target[1] = 9'(wr_merge({23'h000000, r.target[1]}, pwdata, pstrb));
            end
        end

        // Comparator pins are asynchronous to the chopper clock
        next_r.cmp_meta = comp_above;
        next_r.cmp_sync = r.cmp_meta;

        // Each coil steps on its own; nothing couples their cycles
        for (int c = 0; c < 2; c++) begin
            cs = r.coil[c];
            ns = cs;
            cmp = r.cmp_sync[c];
            blanked = (cs.blank_cnt != 6'h00);
            new_cycle = 1'b0;
            if (blanked) begin
                ns.blank_cnt = cs.blank_cnt - 6'h01;
            end
            if (cs.timer != 10'h000) begin
                ns.timer = cs.timer - 10'h001;
            end
            if (cs.drv.phase == PH_ON || cs.drv.phase == PH_FAST) begin
                if (cs.dec_cnt >= dec_last(cf.hyst_decrement_interval)) begin
                    ns.dec_cnt = 6'h00;
                    if (cs.hyst > hyst_end_value_eff(cf.hyst_end_value)) begin
                        ns.hyst = cs.hyst - 6'sh01;
                    end
                end else begin
                    ns.dec_cnt = cs.dec_cnt + 6'h01;
                end
            end
            if (cf.slow_decay_length == 4'h0) begin
                ns.drv.phase = PH_OFF;
                ns.timer = 10'h000;
                ns.blank_cnt = 6'h00;
            end else begin
                unique case (cs.drv.phase)
                    PH_OFF: new_cycle = 1'b1;
                    PH_ON: begin
                        if (!blanked && cmp) begin
                            if (!cf.chopper_scheme_select) begin
                                ns.drv.phase = PH_SLOW1;
                                ns.timer = slow_cycles(cf.slow_decay_length, cf.random_offtime_enable,
                                                       rnd[c*8 +: 4]) - 10'h001;
                            end else if (cf.fast_decay_time != 4'h0) begin
                                ns.drv.phase = PH_FAST;
                                ns.timer = 10'({6'h00, cf.fast_decay_time} * FAST_MULT) - 10'h001;
                                ns.blank_cnt = blank_cycles(cf.blank_interval);
                            end else begin
                                ns.drv.phase = PH_SLOW2;
                                ns.timer = slow_cycles(cf.slow_decay_length, cf.random_offtime_enable,
                                                       rnd[c*8 +: 4]) - 10'h001;
                            end
                        end
                    end
                    PH_SLOW1: begin
                        if (cs.timer == 10'h000) begin
                            ns.drv.phase = PH_FAST;
                            ns.blank_cnt = blank_cycles(cf.blank_interval);
                        end
                    end
                    PH_FAST: begin
                        if ((!cf.chopper_scheme_select && !blanked && !cmp) ||
                            (cf.chopper_scheme_select && (cs.timer == 10'h000 ||
                             (!cf.fast_decay_timer_only && !blanked && !cmp)))) begin
                            ns.drv.phase = PH_SLOW2;
                            ns.timer = slow_cycles(cf.slow_decay_length, cf.random_offtime_enable,
                                                   rnd[c*8 +: 4]) - 10'h001;
                        end
                    end
                    PH_SLOW2: new_cycle = (cs.timer == 10'h000);
                endcase
            end
            if (new_cycle) begin
                ns.drv.phase = PH_ON;
                ns.hyst = hstart_eff(cf);
                ns.dec_cnt = 6'h00;
                ns.blank_cnt = blank_cycles(cf.blank_interval);
            end
            ns.drv.polarity = r.target[c][8];
            ns.drv.threshold = thr_calc(r.target[c][7:0], cf, ns.drv.phase, ns.hyst);
            next_r.coil[c] = ns;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r.conf     <= CONF_RST;
            r.target   <= {TARGET_RST, TARGET_RST};
            r.cmp_meta <= 2'h0;
            r.cmp_sync <= 2'h0;
            for (int c = 0; c < 2; c++) begin
                r.coil[c] <= '{drv: '{phase: PH_OFF, polarity: 1'b0, threshold: 8'h00},
                               timer: 10'h000, blank_cnt: 6'h00, dec_cnt: 6'h00, hyst: 6'sh00};
            end
            r.pready   <= 1'b0;
            r.pslverr  <= 1'b0;
            r.prdata   <= 32'h00000000;
        end else begin
            r <= next_r;
        end
    end

    assign prdata  = r.prdata;
    assign pready  = r.pready;
    assign pslverr = r.pslverr;
    assign coil_drive[0] = r.coil[0].drv;
    assign coil_drive[1] = r.coil[1].drv;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_freewheel_off: assert property (
        r.conf.slow_decay_length == 4'h0 |=> r.coil[0].drv.phase == PH_OFF && r.coil[1].drv.phase == PH_OFF)
        else $error("coil not freewheeling with zero slow decay length");

    a_hyst_on_slow: assert property (
        ($past(r.coil[0].drv.phase) == PH_ON && !$past(r.conf.chopper_scheme_select) &&
         $past(r.conf.slow_decay_length) != 4'h0 && r.coil[0].drv.phase != PH_ON) |-> r.coil[0].drv.phase == PH_SLOW1)
        else $error("hysteresis on phase not followed by slow decay");

    a_slow_length: assert property (
        (r.coil[0].drv.phase == PH_SLOW1 && $past(r.coil[0].drv.phase) == PH_ON &&
         !$past(r.conf.random_offtime_enable)) |->
        r.coil[0].timer == 10'({6'h00, $past(r.conf.slow_decay_length)} * 10'h020 + 10'h017))
        else $error("slow decay timer loaded with wrong length");

    a_blank_mask: assert property (
        (r.coil[1].drv.phase == PH_ON && r.coil[1].blank_cnt != 6'h00 && r.conf.slow_decay_length != 4'h0)
        |=> r.coil[1].drv.phase == PH_ON)
        else $error("on phase ended during blanking");

    a_blank_load: assert property (
        (r.coil[0].drv.phase == PH_ON && $past(r.coil[0].drv.phase) != PH_ON) |->
        r.coil[0].blank_cnt == blank_cycles($past(r.conf.blank_interval)))
        else $error("blanking count not loaded at on phase start");

    a_hyst_start: assert property (
        (r.coil[0].drv.phase == PH_ON && $past(r.coil[0].drv.phase) != PH_ON) |->
        r.coil[0].hyst == $signed({2'h0, $past(r.conf.hyst_end_value)}) - 6'sh03 +
                          $signed({3'h0, $past(r.conf.hyst_start_offset)}) + 6'sh01)
        else $error("hysteresis start value wrong");

    a_hold_in_slow: assert property (
        (r.coil[1].drv.phase == PH_SLOW1 || (r.coil[1].drv.phase == PH_SLOW2 && r.coil[1].timer != 10'h000))
        |=> $stable(r.coil[1].hyst))
        else $error("hysteresis changed during slow decay");

    a_dec_interval: assert property (
        ($past(r.coil[0].drv.phase) inside {PH_ON, PH_FAST} && r.coil[0].hyst < $past(r.coil[0].hyst)) |->
        $past(r.coil[0].dec_cnt) >= dec_last($past(r.conf.hyst_decrement_interval)))
        else $error("hysteresis decremented before its interval");

    a_timer_only: assert property (
        (r.coil[0].drv.phase == PH_FAST && r.conf.chopper_scheme_select && r.conf.fast_decay_timer_only &&
         r.coil[0].timer != 10'h000 && r.conf.slow_decay_length != 4'h0) |=> r.coil[0].drv.phase == PH_FAST)
        else $error("timed fast decay ended early");

    a_offtime_fast: assert property (
        ($past(r.coil[1].drv.phase) == PH_ON && $past(r.conf.chopper_scheme_select) &&
         $past(r.conf.slow_decay_length) != 4'h0 && r.coil[1].drv.phase != PH_ON) |->
        r.coil[1].drv.phase == (($past(r.conf.fast_decay_time) == 4'h0) ? PH_SLOW2 : PH_FAST))
        else $error("off-time on phase followed by wrong phase");
endmodule
`default_nettype wire

/* File: verilog/ccc_lfsr.sv */
`default_nettype none
module ccc_lfsr
    import ccc_pkg::*;
#(
    parameter int          WIDTH = 16,
    parameter logic [15:0] TAPS  = 16'hB400,
    parameter logic [15:0] SEED  = 16'hACE1
) (
    input  wire logic             pclk,    // System clock
    input  wire logic             presetn, // Async reset, active low
    output logic      [WIDTH-1:0] rnd      // Free-running pseudo-random word
);
    typedef struct packed {
        logic [WIDTH-1:0] shift;
    } ccc_lfsr_state_t;

    ccc_lfsr_state_t r;
    ccc_lfsr_state_t next_r;

    // Galois form; a nonzero seed keeps it out of the stuck all-zero state
    always_comb begin
        next_r = r;
        next_r.shift = {1'b0, r.shift[WIDTH-1:1]};
        if (r.shift[0]) begin
            next_r.shift = next_r.shift ^ TAPS[WIDTH-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= SEED[WIDTH-1:0];
        end else begin
            r <= next_r;
        end
    end

    assign rnd = r.shift;
endmodule
`default_nettype wire

/* File: verilog/ccc_pkg.sv */
`default_nettype none
package ccc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CONF     = 8'h00;
    localparam logic [7:0] OFS_TARGET_A = 8'h04;
    localparam logic [7:0] OFS_TARGET_B = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0C;

    // Chopper timing in system clock cycles, then threshold biases
    localparam logic [9:0] SLOW_MULT   = 10'h020;
    localparam logic [9:0] SLOW_BASE   = 10'h018;
    localparam logic [9:0] FAST_MULT   = 10'h020;
    localparam logic [5:0] BLANK_0     = 6'h10;
    localparam logic [5:0] BLANK_1     = 6'h18;
    localparam logic [5:0] BLANK_2     = 6'h24;
    localparam logic [5:0] BLANK_3     = 6'h36;
    localparam logic [6:0] HYST_DECREMENT_INTERVAL_STEP   = 7'h10;
    localparam logic [5:0] HYST_END_VALUE_BIAS   = 6'h03;
    localparam logic [5:0] OFFSET_BIAS = 6'h03;

    typedef enum logic [4:0] {
        PH_OFF   = 5'b00001,
        PH_ON    = 5'b00010,
        PH_SLOW1 = 5'b00100,
        PH_FAST  = 5'b01000,
        PH_SLOW2 = 5'b10000
    } ccc_phase_t;

    typedef struct packed {
        logic       fast_decay_timer_only;
        logic [3:0] sine_offset;
        logic [3:0] fast_decay_time;
        logic       random_offtime_enable;
        logic [1:0] hyst_decrement_interval;
        logic [3:0] hyst_end_value;
        logic [2:0] hyst_start_offset;
        logic       chopper_scheme_select;
        logic [1:0] blank_interval;
        logic [3:0] slow_decay_length;
    } ccc_conf_t;

    localparam ccc_conf_t CONF_RST = 26'h0000000;
    localparam logic [8:0] TARGET_RST = 9'h000;

    typedef struct packed {
        ccc_phase_t phase;
        logic       polarity;
        logic [7:0] threshold;
    } ccc_drive_t;

    typedef struct packed {
        ccc_drive_t        drv;
        logic [9:0]        timer;
        logic [5:0]        blank_cnt;
        logic [5:0]        dec_cnt;
        logic signed [5:0] hyst;
    } ccc_coil_t;

endpackage
`default_nettype wire
